/* rtl/rspc_map.vh */
// Constants for the reset strap and pin configuration block
`ifndef RSPC_MAP_VH
`define RSPC_MAP_VH
// Register byte offsets on the AXI4-Lite slave
`define RSPC_OFF_CTRL 8'h00
`define RSPC_OFF_STRAP 8'h04
`define RSPC_OFF_VOL 8'h08
`define RSPC_OFF_STAT 8'h0c
`define RSPC_OFF_DEC 8'h10
// Control register fields
`define RSPC_CTRL_GPO0 0
`define RSPC_CTRL_GPO1 1
`define RSPC_CTRL_GPOEN 2
`define RSPC_CTRL_VOLUME_BUTTONS_ENABLE 3
`define RSPC_CTRL_VCF 4
`define RSPC_CTRL_EEP 5
`define RSPC_CTRL_RST 8'h00
// Strap register fields
`define RSPC_STRAP_PORT 0
`define RSPC_STRAP_ALT 1
`define RSPC_STRAP_MCLK 2
`define RSPC_STRAP_SDO 3
// Status register fields
`define RSPC_STAT_INIT 0
`define RSPC_STAT_ISOL 1
`define RSPC_STAT_MUTE 2
// Configuration address ports
`define RSPC_PORT_STD 12'h279
`define RSPC_PORT_ALT_HI 12'h308
`define RSPC_PORT_ALT_LO 12'h388
// Volume step range and reset level
`define RSPC_VOL_MAX 6'h3f
`define RSPC_VOL_RST 6'h20
// Timing in microseconds, and cycles per microsecond at 100 MHz
`define RSPC_CLK_MHZ 100
`define RSPC_DEBOUNCE_US 10000
`define RSPC_REPEAT_US 200000
`define RSPC_CAL_US 10205
`define RSPC_EEP_US_PER_BYTE 100
`endif

/* rtl/rspc_debounce.v */
// Button synchroniser and debounce filter
`timescale 1ns/1ps
module rspc_debounce #(
   parameter CNT_W = 24,
   parameter [23:0] STABLE = 24'd1000000
) (
   clk_sys,
   arst_n,
   btn_n,
   pressed
);
   input wire clk_sys;
   input wire arst_n;
   input wire btn_n;
   output reg pressed;
   reg sync1_r;
   reg sync2_r;
   reg [CNT_W-1:0] cnt_r;
   // Two-stage sync, then require stable level for STABLE+1 cycles
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
         cnt_r <= {CNT_W{1'b0}};
         pressed <= 1'b0;
      end else begin
         sync1_r <= btn_n;
         sync2_r <= sync1_r;
         if ((!sync2_r) == pressed) begin
            cnt_r <= {CNT_W{1'b0}};
         end else if (cnt_r >= STABLE[CNT_W-1:0]) begin
            cnt_r <= {CNT_W{1'b0}};
            pressed <= !sync2_r;
         end else begin
            cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
         end
      end
   end
endmodule // rspc_debounce

/* rtl/rspc_volume.v */
// Master volume and mute state driven by the buttons
`timescale 1ns/1ps
`include "rspc_map.vh"
module rspc_volume #(
   parameter [31:0] REPEAT_CYC = 32'd20000000
) (
   clk_sys,
   arst_n,
   enable,
   fmt,
   init_busy,
   up_p,
   dn_p,
   mute_p,
   vol,
   muted
);
   input wire clk_sys;
   input wire arst_n;
   input wire enable;
   input wire fmt;
   input wire init_busy;
   input wire up_p;
   input wire dn_p;
   input wire mute_p;
   output reg [5:0] vol;
   output reg muted;
   reg [31:0] rep_r;
   reg up_d_r;
   reg dn_d_r;
   reg mute_d_r;
   wire both = up_p & dn_p;
   wire one = up_p ^ dn_p;
   wire new_press = (up_p & !up_d_r) | (dn_p & !dn_d_r);
   wire rep_hit = one & (rep_r == REPEAT_CYC);
   wire step = one & (new_press | rep_hit);
   // Master volume after the output mixer; mute tracked alongside
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         vol <= `RSPC_VOL_RST;
         muted <= 1'b1;
         rep_r <= 32'h0;
         up_d_r <= 1'b0;
         dn_d_r <= 1'b0;
         mute_d_r <= 1'b0;
      end else if (init_busy) begin
         vol <= `RSPC_VOL_RST;
         muted <= 1'b1;
         rep_r <= 32'h0;
      end else begin
         up_d_r <= up_p;
         dn_d_r <= dn_p;
         mute_d_r <= mute_p;
         // Repeat timer restarts on each step while held
         if (!one || step) begin
            rep_r <= 32'h0;
         end else begin
            rep_r <= rep_r + 32'h1;
         end
         if (enable) begin
            if (step && up_p && vol != `RSPC_VOL_MAX) begin
               vol <= vol + 6'h1;
            end else if (step && dn_p && vol != 6'h00) begin
               vol <= vol - 6'h1;
            end
            if (fmt && both) begin
               muted <= 1'b1;
            end else if (step) begin
               muted <= 1'b0;
            end else if (!fmt && mute_p && !mute_d_r) begin
               muted <= !muted;
            end
         end
      end
   end
endmodule // rspc_volume

/* rtl/rspc_top.v */
// Reset straps, pin muxing, init sequencing and hardware volume
//
// The AXI4-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "rspc_map.vh"
// Summary of operation
// - Port-select and alternate-port straps latch on falling bus reset.
// - Port-select high gives configuration port 0x279.
// - Port-select low gives 0x308 or 0x388 per alternate strap.
// - Relocated port still accepts all commands and both unlock keys.
// - Master-clock and serial-out straps latch on same falling edge.
// - Master-clock high turns four CD pins into SA12..SA15 inputs.
// - Volume-button enable forces shared pin to volume-down input.
// - Else shared pin is general output 1 or alternate CD select.
// - Enabled general outputs follow two pin-control bits directly.
// - Bus reset high resets config, disables devices, mutes outputs.
// - After reset falls, run calibration, then isolated at reset values.
// - Initialization length depends on EEPROM presence and size.
// - Volume buttons act only while their enable bit is set.
// - Buttons change master volume after the output mixer.
// - Low up input steps volume up, low down steps down.
// - Holding a button keeps stepping in the same direction.
// - Format 0: each mute press toggles mute.
// - Three-button format: up or down unmutes.
// - Format 1: ignore mute pin; both mutes, single unmutes.
// - Upper address mode decodes only when SA15..SA12 are zero.
module rspc_top #(
   parameter [23:0] DEBOUNCE_CYC = 24'd1000000,
   parameter [31:0] REPEAT_CYC = 32'd20000000,
   parameter [31:0] CAL_CYC = 32'd1020500,
   parameter [31:0] EEP_CYC_PER_BYTE = 32'd10000
) (
   clk_sys,
   arst_n,
   bus_reset_in,
   port_select_strap,
   alt_port_strap,
   mclk_strap,
   shared_pin_mode_strap,
   eeprom_present,
   eeprom_bytes,
   cd_chip_select_in,
   cd_dma_ack_in,
   cd_interrupt_in,
   cd_dma_request_in,
   cd_pins_are_addr,
   upper_addr_ok,
   host_addr_lo,
   config_port_hit,
   config_port,
   shared_pin_out,
   shared_pin_oe_n,
   shared_pin_in,
   alt_cd_chip_select_n,
   general_output_0,
   vol_up_n,
   vol_mute_n,
   init_busy,
   bus_isolated,
   devices_enabled,
   master_volume,
   master_muted,
   s_axi_awaddr,
   s_axi_awvalid,
   s_axi_awready,
   s_axi_wdata,
   s_axi_wstrb,
   s_axi_wvalid,
   s_axi_wready,
   s_axi_bresp,
   s_axi_bvalid,
   s_axi_bready,
   s_axi_araddr,
   s_axi_arvalid,
   s_axi_arready,
   s_axi_rdata,
   s_axi_rresp,
   s_axi_rvalid,
   s_axi_rready
);
   input wire clk_sys;
   input wire arst_n;
   input wire bus_reset_in;
   input wire port_select_strap;
   input wire alt_port_strap;
   input wire mclk_strap;
   input wire shared_pin_mode_strap;
   input wire eeprom_present;
   input wire [11:0] eeprom_bytes;
   input wire cd_chip_select_in;
   input wire cd_dma_ack_in;
   input wire cd_interrupt_in;
   input wire cd_dma_request_in;
   output wire cd_pins_are_addr;
   output wire upper_addr_ok;
   input wire [11:0] host_addr_lo;
   output wire config_port_hit;
   output reg [11:0] config_port;
   output reg shared_pin_out;
   output reg shared_pin_oe_n;
   input wire shared_pin_in;
   output reg alt_cd_chip_select_n;
   output reg general_output_0;
   input wire vol_up_n;
   input wire vol_mute_n;
   output wire init_busy;
   output wire bus_isolated;
   output reg devices_enabled;
   output wire [5:0] master_volume;
   output wire master_muted;
   input wire [7:0] s_axi_awaddr;
   input wire s_axi_awvalid;
   output wire s_axi_awready;
   input wire [31:0] s_axi_wdata;
   input wire [3:0] s_axi_wstrb;
   input wire s_axi_wvalid;
   output wire s_axi_wready;
   output reg [1:0] s_axi_bresp;
   output reg s_axi_bvalid;
   input wire s_axi_bready;
   input wire [7:0] s_axi_araddr;
   input wire s_axi_arvalid;
   output wire s_axi_arready;
   output reg [31:0] s_axi_rdata;
   output reg [1:0] s_axi_rresp;
   output reg s_axi_rvalid;
   input wire s_axi_rready;

   // One-hot init sequencer states
   localparam [3:0] ST_RESET = 4'b0001;
   localparam [3:0] ST_CAL = 4'b0010;
   localparam [3:0] ST_EEP = 4'b0100;
   localparam [3:0] ST_IDLE = 4'b1000;

   reg [3:0] state_r;
   reg [3:0] state_nxt;
   reg [31:0] cnt_r;
   reg [31:0] cnt_nxt;
   reg bus_reset_d_r;
   reg [3:0] strap_r;
   reg isolated_r;
   reg [7:0] ctrl_r;
   reg [7:0] aw_addr_r;
   reg aw_full_r;
   reg [31:0] w_data_r;
   reg [3:0] w_strb_r;
   reg w_full_r;
   wire [5:0] vol;
   wire mute;
   wire up_p;
   wire dn_p;
   wire mute_p;
   wire bus_reset_fall = bus_reset_d_r & !bus_reset_in;
   wire volume_buttons_enable = ctrl_r[`RSPC_CTRL_VOLUME_BUTTONS_ENABLE];
   wire [31:0] eep_cyc = eeprom_present ?
      EEP_CYC_PER_BYTE * {20'h0, eeprom_bytes} : 32'h0;

   ////////////////////////////////////////////////////////////////////////////
   // Strap capture on the falling edge of the bus reset
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         bus_reset_d_r <= 1'b1;
         strap_r <= 4'hf; // Internal pull-ups read high
      end else begin
         bus_reset_d_r <= bus_reset_in;
         if (bus_reset_fall) begin
            strap_r[`RSPC_STRAP_PORT] <= port_select_strap;
            strap_r[`RSPC_STRAP_ALT] <= alt_port_strap;
            strap_r[`RSPC_STRAP_MCLK] <= mclk_strap;
            strap_r[`RSPC_STRAP_SDO] <= shared_pin_mode_strap;
         end
      end
   end

   // Configuration port follows the latched straps
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         config_port <= `RSPC_PORT_STD;
      end else if (strap_r[`RSPC_STRAP_PORT]) begin
         config_port <= `RSPC_PORT_STD;
      end else if (strap_r[`RSPC_STRAP_ALT]) begin
         config_port <= `RSPC_PORT_ALT_HI;
      end else begin
         config_port <= `RSPC_PORT_ALT_LO;
      end
   end

   // Same decode whatever port: all commands and keys go through it
   assign cd_pins_are_addr = strap_r[`RSPC_STRAP_MCLK];
   assign upper_addr_ok = !cd_pins_are_addr | ({cd_dma_request_in, cd_interrupt_in,
      cd_dma_ack_in, cd_chip_select_in} == 4'h0);
   assign config_port_hit = (host_addr_lo == config_port) & upper_addr_ok;

   ////////////////////////////////////////////////////////////////////////////
   // Init sequencer: calibration, then EEPROM load, then isolated idle
   always @* begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      case (state_r)
         ST_RESET: begin
            cnt_nxt = 32'h0;
            if (!bus_reset_in) begin
               state_nxt = ST_CAL;
            end
         end
         ST_CAL: begin
            cnt_nxt = cnt_r + 32'h1;
            if (cnt_r >= CAL_CYC - 32'h1) begin
               cnt_nxt = 32'h0;
               state_nxt = ST_EEP;
            end
         end
         ST_EEP: begin
            cnt_nxt = cnt_r + 32'h1;
            if (cnt_r >= eep_cyc) begin
               state_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            cnt_nxt = 32'h0;
         end
         default: begin
            state_nxt = ST_RESET;
            cnt_nxt = 32'h0;
         end
      endcase
      if (bus_reset_in) begin
         state_nxt = ST_RESET;
      end
   end

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r <= ST_RESET;
         cnt_r <= 32'h0;
      end else begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   assign init_busy = !state_r[3];
   // Isolation ends only when software enables devices after init
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         isolated_r <= 1'b1;
         devices_enabled <= 1'b0;
      end else if (init_busy) begin
         isolated_r <= 1'b1;
         devices_enabled <= 1'b0;
      end else begin
         devices_enabled <= ctrl_r[`RSPC_CTRL_GPOEN];
         isolated_r <= !ctrl_r[`RSPC_CTRL_GPOEN];
      end
   end
   assign bus_isolated = isolated_r;

   ////////////////////////////////////////////////////////////////////////////
   // Shared pin and general outputs
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         shared_pin_out <= 1'b0;
         shared_pin_oe_n <= 1'b1;
         alt_cd_chip_select_n <= 1'b1;
         general_output_0 <= 1'b0;
      end else begin
         general_output_0 <= ctrl_r[`RSPC_CTRL_GPOEN] & ctrl_r[`RSPC_CTRL_GPO0];
         alt_cd_chip_select_n <= 1'b1;
         if (volume_buttons_enable) begin
            shared_pin_oe_n <= 1'b1;
            shared_pin_out <= 1'b0;
         end else if (strap_r[`RSPC_STRAP_SDO]) begin
            shared_pin_oe_n <= 1'b0;
            shared_pin_out <= ctrl_r[`RSPC_CTRL_GPOEN] & ctrl_r[`RSPC_CTRL_GPO1];
         end else begin
            shared_pin_oe_n <= 1'b0;
            shared_pin_out <= cd_chip_select_in;
            alt_cd_chip_select_n <= cd_chip_select_in;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Buttons: down comes from the shared pin only when enabled
   rspc_debounce #(.CNT_W(24), .STABLE(DEBOUNCE_CYC)) u_db_up (
      .clk_sys(clk_sys), .arst_n(arst_n), .btn_n(vol_up_n), .pressed(up_p));
   rspc_debounce #(.CNT_W(24), .STABLE(DEBOUNCE_CYC)) u_db_dn (
      .clk_sys(clk_sys), .arst_n(arst_n), .btn_n(shared_pin_in | !volume_buttons_enable), .pressed(dn_p));
   rspc_debounce #(.CNT_W(24), .STABLE(DEBOUNCE_CYC)) u_db_mute (
      .clk_sys(clk_sys), .arst_n(arst_n), .btn_n(vol_mute_n), .pressed(mute_p));

   rspc_volume #(.REPEAT_CYC(REPEAT_CYC)) u_vol (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .enable(volume_buttons_enable),
      .fmt(ctrl_r[`RSPC_CTRL_VCF]),
      .init_busy(init_busy),
      .up_p(up_p),
      .dn_p(dn_p),
      .mute_p(mute_p),
      .vol(vol),
      .muted(mute)
   );
   assign master_volume = vol;
   assign master_muted = mute;

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite slave: address and data accepted in either order
   assign s_axi_awready = !aw_full_r & !s_axi_bvalid;
   assign s_axi_wready = !w_full_r & !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         aw_full_r <= 1'b0;
         w_full_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0;
         w_strb_r <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         ctrl_r <= `RSPC_CTRL_RST;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (aw_full_r && w_full_r) begin
            aw_full_r <= 1'b0;
            w_full_r <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= 2'b00;
            if ({2'b00, aw_addr_r[7:2]} == (`RSPC_OFF_CTRL >> 2)) begin
               if (w_strb_r[0]) begin
                  ctrl_r <= w_data_r[7:0];
               end
            end else if ({2'b00, aw_addr_r[7:2]} > (`RSPC_OFF_DEC >> 2)) begin
               s_axi_bresp <= 2'b10; // Unmapped answers SLVERR
            end
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         // Bus reset returns control bits to reset values
         if (bus_reset_in) begin
            ctrl_r <= `RSPC_CTRL_RST;
         end
      end
   end

   // Reads answer one cycle after the address is taken
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0;
         s_axi_rresp <= 2'b00;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rvalid <= 1'b1;
         s_axi_rresp <= 2'b00;
         case ({2'b00, s_axi_araddr[7:2]})
            `RSPC_OFF_CTRL >> 2: s_axi_rdata <= {24'h0, ctrl_r};
            `RSPC_OFF_STRAP >> 2: s_axi_rdata <= {28'h0, strap_r};
            `RSPC_OFF_VOL >> 2: s_axi_rdata <= {26'h0, vol};
            `RSPC_OFF_STAT >> 2: s_axi_rdata <= {29'h0, mute, isolated_r, init_busy};
            `RSPC_OFF_DEC >> 2: s_axi_rdata <= {20'h0, config_port};
            default: begin
               s_axi_rdata <= 32'h0;
               s_axi_rresp <= 2'b10;
            end
         endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
      end
   end
endmodule // rspc_top

/* verification/rspc_top_props.sv */
// Port-level checks for the strap and pin configuration block
`timescale 1ns/1ps
module rspc_top_props (
   input wire logic clk_sys,
   input wire logic arst_n,
   input wire logic bus_reset_in,
   input wire logic port_select_strap,
   input wire logic alt_port_strap,
   input wire logic mclk_strap,
   input wire logic cd_chip_select_in,
   input wire logic cd_dma_ack_in,
   input wire logic cd_interrupt_in,
   input wire logic cd_dma_request_in,
   input wire logic cd_pins_are_addr,
   input wire logic upper_addr_ok,
   input wire logic [11:0] host_addr_lo,
   input wire logic config_port_hit,
   input wire logic [11:0] config_port,
   input wire logic init_busy,
   input wire logic bus_isolated,
   input wire logic devices_enabled,
   input wire logic [5:0] master_volume,
   input wire logic master_muted,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic [1:0] s_axi_rresp
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   ////////////////////////////////////////////////////////////
   // Straps settle a few cycles after bus reset falls
   port_sel_a: assert property (
      $fell(bus_reset_in) |-> ##4 config_port == (port_select_strap ? 12'h279 :
         (alt_port_strap ? 12'h308 : 12'h388))) else $error("config port wrong");
   cd_mode_a: assert property (
      $fell(bus_reset_in) |-> ##4 cd_pins_are_addr == mclk_strap)
      else $error("cd pin mode wrong");
   upper_ok_a: assert property (
      upper_addr_ok == !(cd_pins_are_addr && (cd_chip_select_in || cd_dma_ack_in ||
         cd_interrupt_in || cd_dma_request_in))) else $error("upper decode wrong");
   port_hit_a: assert property (
      config_port_hit == (host_addr_lo == config_port && upper_addr_ok))
      else $error("port hit wrong");
   // Reset held three cycles must leave the part quiet
   reset_quiet_a: assert property (
      bus_reset_in [*3] |-> master_muted && !devices_enabled && init_busy)
      else $error("bus reset not quiet");
   calib_run_a: assert property (
      $fell(bus_reset_in) |-> init_busy [*8]) else $error("init too short");
   init_isol_a: assert property (
      $fell(init_busy) |-> bus_isolated) else $error("not isolated after init");
   vol_step_a: assert property (
      !$stable(master_volume) && !$past(init_busy) |->
         (master_volume == $past(master_volume) + 6'h01) ||
         (master_volume == $past(master_volume) - 6'h01)) else $error("volume jump");
   read_answer_a: assert property (
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
   read_block_a: assert property (
      s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
   cover property ($fell(bus_reset_in)); // Main scenarios
   cover property ($fell(master_muted));
   cover property (config_port_hit && cd_pins_are_addr);
   cover property (s_axi_rvalid && s_axi_rresp == 2'b10);
endmodule // rspc_top_props

/* verification/rspc_buttons.sv */
// Front-panel push-button model with contact chatter
`timescale 1ns/1ps
module rspc_buttons (
   input wire logic clk_sys,
   input wire logic up_press,
   input wire logic dn_press,
   input wire logic mute_press,
   output logic vol_up_n,
   output logic vol_down_n,
   output logic vol_mute_n
);
   logic [2:0] held_r = 3'h0;
   logic [1:0] chat_r = 2'h0;
   ////////////////////////////////////////////////////////////
   // Chatter lasts three cycles after any change, so debounce is really needed
   always @(posedge clk_sys) begin
      held_r <= {up_press, dn_press, mute_press};
      if (held_r != {up_press, dn_press, mute_press})
         chat_r <= 2'h3;
      else if (chat_r != 2'h0)
         chat_r <= chat_r - 2'h1;
   end
   // Pull-ups hold released lines high; pressed contacts bounce open
   assign vol_up_n = ~(up_press & ~chat_r[0]);
   assign vol_down_n = ~(dn_press & ~chat_r[0]);
   assign vol_mute_n = ~(mute_press & ~chat_r[0]);
endmodule // rspc_buttons

/* verification/test_reset_strap_pin_config.sv */
// Self-checking bench for the strap and pin configuration block
`timescale 1ns/1ps
module test_reset_strap_pin_config;
   logic clk_sys = 1'b0, arst_n = 1'b0, bus_reset_in = 1'b0, eeprom_present = 1'b0;
   logic port_select_strap = 1'b1, alt_port_strap = 1'b1, mclk_strap = 1'b1;
   logic shared_pin_mode_strap = 1'b1, cd_chip_select_in = 1'b0, cd_dma_ack_in = 1'b0;
   logic cd_interrupt_in = 1'b0, cd_dma_request_in = 1'b0, up_c = 1'b0, dn_c = 1'b0;
   logic mu_c = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [11:0] eeprom_bytes = 12'h000, host_addr_lo = 12'h000;
   logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0, rd;
   logic [3:0] s_axi_wstrb = 4'h0, r4, k;
   logic [1:0] rs;
   wire cd_pins_are_addr, upper_addr_ok, config_port_hit, shared_pin_out, shared_pin_oe_n;
   wire shared_pin_in, alt_cd_chip_select_n, general_output_0, vol_up_n, vol_mute_n;
   wire init_busy, bus_isolated, devices_enabled, master_muted;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   wire [11:0] config_port;
   wire [5:0] master_volume;
   wire [1:0] s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   int errors = 0, n_compared = 0, cyc = 0, n0, n1, b;
   ////////////////////////////////////////////////////////////
   // Short counts keep the run brief; expectations use these figures
   rspc_top #(.DEBOUNCE_CYC(24'd4), .REPEAT_CYC(32'd20), .CAL_CYC(32'd10),
      .EEP_CYC_PER_BYTE(32'd2)) rspc_top_i (.*);
   rspc_buttons rspc_buttons_i (.clk_sys(clk_sys), .up_press(up_c), .dn_press(dn_c),
      .mute_press(mu_c), .vol_up_n(vol_up_n), .vol_down_n(shared_pin_in),
      .vol_mute_n(vol_mute_n));
   always #5 clk_sys = ~clk_sys;
   // Hang guard, far above the thousand or so cycles the run needs
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         errors++;
         close_out();
      end
   end
   task close_out();
      $display("compared %0d mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [11:0] exp_port(input logic ps, input logic alt);
      return ps ? 12'h279 : (alt ? 12'h308 : 12'h388);
   endfunction
   // Readies are looked at mid-cycle, so the next rising edge is the handshake
   task axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic ta, tw;
      @(posedge clk_sys);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_wstrb <= 4'hf;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      @(negedge clk_sys);
      while (s_axi_awvalid || s_axi_wvalid) begin
         ta = s_axi_awvalid && s_axi_awready;
         tw = s_axi_wvalid && s_axi_wready;
         @(posedge clk_sys);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         @(negedge clk_sys);
      end
      while (!s_axi_bvalid) @(negedge clk_sys);
      r = s_axi_bresp;
      @(posedge clk_sys);
      s_axi_bready <= 1'b0;
   endtask
   task axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      @(posedge clk_sys);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      @(negedge clk_sys);
      while (!s_axi_arready) @(negedge clk_sys);
      @(posedge clk_sys);
      s_axi_arvalid <= 1'b0;
      @(negedge clk_sys);
      while (!s_axi_rvalid) @(negedge clk_sys);
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge clk_sys);
      s_axi_rready <= 1'b0;
   endtask
   // Straps are {serial out, master clock, alternate, port select}
   task breset(input logic [3:0] s, output int n);
      @(posedge clk_sys);
      bus_reset_in <= 1'b1;
      {shared_pin_mode_strap, mclk_strap, alt_port_strap, port_select_strap} <= s;
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys);
      chk(master_muted, 1'b1);
      chk(devices_enabled, 1'b0);
      @(posedge clk_sys);
      bus_reset_in <= 1'b0;
      n = 0;
      @(negedge clk_sys);
      // No host access until the part reports ready
      while (init_busy && n < 5000) begin
         n++;
         @(negedge clk_sys);
      end
      chk(bus_isolated, 1'b1);
   endtask
   task press(input logic [2:0] p, input int hold);
      @(posedge clk_sys);
      {up_c, dn_c, mu_c} <= p;
      repeat (hold) @(posedge clk_sys);
      {up_c, dn_c, mu_c} <= 3'h0;
      repeat (30) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h199e));
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      // Every port strap pair, random pin-mode straps, random upper address
      for (int i = 0; i < 4; i++) begin
         r4 = 4'($urandom);
         r4[1:0] = i[1:0];
         breset(r4, n0);
         chk(config_port, exp_port(r4[0], r4[1]));
         chk(cd_pins_are_addr, r4[2]);
         axr(8'h04, rd, rs);
         chk(rd, {28'h0, r4});
         for (int j = 0; j < 2; j++) begin
            k = (j == 0) ? 4'h0 : 4'($urandom);
            @(posedge clk_sys);
            {cd_dma_request_in, cd_interrupt_in, cd_dma_ack_in, cd_chip_select_in} <= k;
            host_addr_lo <= exp_port(r4[0], r4[1]);
            @(negedge clk_sys);
            chk(upper_addr_ok, !r4[2] || k == 4'h0);
            chk(config_port_hit, !r4[2] || k == 4'h0);
         end
      end
      $display("strap test done");
      b = $urandom_range(40, 1);
      @(posedge clk_sys);
      eeprom_present <= 1'b1;
      eeprom_bytes <= 12'(b);
      {cd_dma_request_in, cd_interrupt_in, cd_dma_ack_in, cd_chip_select_in} <= 4'h0;
      breset(4'b1001, n1);
      chk(n1 - n0, 2 * b);
      $display("init length test done");
      for (int i = 0; i < 4; i++) begin
         r4 = 4'($urandom) & 4'h7;
         axw(8'h00, {28'h0, r4}, rs);
         repeat (2) @(negedge clk_sys);
         chk(general_output_0, r4[2] & r4[0]);
         chk(shared_pin_out, r4[2] & r4[1]);
         chk(shared_pin_oe_n, 1'b0);
      end
      axw(8'h00, 32'h0000000c, rs);
      repeat (2) @(negedge clk_sys);
      chk(shared_pin_oe_n, 1'b1);
      breset(4'b0000, n1);
      for (int i = 0; i < 2; i++) begin
         @(posedge clk_sys);
         cd_chip_select_in <= i[0];
         repeat (2) @(negedge clk_sys);
         chk(alt_cd_chip_select_n, i[0]);
      end
      $display("pin mux test done");
      axw(8'h00, 32'h00000004, rs);
      press(3'b100, 15);
      chk(master_volume, 6'h20);
      axw(8'h00, 32'h0000000c, rs);
      press(3'b001, 15);
      chk(master_muted, 1'b0);
      press(3'b100, 2);
      chk(master_volume, 6'h20);
      press(3'b100, 15);
      chk(master_volume, 6'h21);
      press(3'b010, 15);
      chk(master_volume, 6'h20);
      press(3'b100, 60);
      chk(master_volume, 6'h23);
      press(3'b001, 15);
      chk(master_muted, 1'b1);
      press(3'b010, 15);
      chk(master_muted, 1'b0);
      axw(8'h00, 32'h0000001c, rs);
      press(3'b001, 15);
      chk(master_muted, 1'b0);
      press(3'b110, 15);
      chk(master_muted, 1'b1);
      press(3'b100, 15);
      chk(master_muted, 1'b0);
      $display("button test done");
      breset(4'hf, n1);
      axr(8'h00, rd, rs);
      chk(rd, 32'h0);
      axr(8'h20, rd, rs);
      chk(rs, 2'b10);
      chk(rd, 32'h0);
      axw(8'h20, 32'h0, rs);
      chk(rs, 2'b10);
      $display("register test done");
      close_out();
   end
endmodule // test_reset_strap_pin_config
bind rspc_top rspc_top_props rspc_top_props_i (.*);
